// >>> rtl/osm_params.svh
// constants of the eight-lane select register map and its parameter table bytes
// assumes inclusion by osm_pkg.sv and the design modules, in any order
`ifndef OSM_PARAMS_SVH
`define OSM_PARAMS_SVH

// register command codes
`define OSM_CMD_WR_REG 8'h71
`define OSM_CMD_RD_REG 8'h65

// register addresses
`define OSM_ADDR_NV_CFG5 24'h000006
`define OSM_ADDR_VOL_CFG5 24'h800006

// position of the eight-lane select bit in both copies
`define OSM_SEL_BIT 0

// reset and power-up values
`define OSM_NV_CFG5_DEFAULT 8'h00
`define OSM_VOL_CFG5_RESET 8'h00

// parameter table byte addresses of the select map
`define OSM_TBL_FIRST 9'h1A2
`define OSM_TBL_LAST 9'h1AF
`define OSM_TBL_VOL_DESC 9'h1AB
`define OSM_TBL_VOL_ADDR 9'h1AA
`define OSM_TBL_NV_DESC 9'h1AF
`define OSM_TBL_NV_ADDR 9'h1AE
`define OSM_TBL_UNSUPP_A 9'h1A2
`define OSM_TBL_UNSUPP_B 9'h1A6
`define OSM_TBL_VOL_WR 9'h1A8
`define OSM_TBL_VOL_RD 9'h1A9
`define OSM_TBL_NV_WR 9'h1AC
`define OSM_TBL_NV_RD 9'h1AD

// descriptor fields of the top byte of each select map double-word
`define OSM_DESC_SUPPORTED 1'h1
`define OSM_DESC_POL_POSITIVE 1'h0
`define OSM_DESC_NO_OTP 1'h0
`define OSM_DESC_BY_ADDR_CMD 1'h1
`define OSM_DESC_RSVD 1'h0
`define OSM_DESC_BITLOC 3'h0
`define OSM_TBL_NOT_SUPP 8'hFF
`define OSM_TBL_FILL 8'h00

`endif

// >>> rtl/osm_pkg.sv
// types shared by the eight-lane select map block
// assumes osm_params.svh on the include path
`include "osm_params.svh"

package osm_pkg;

    typedef enum logic [1:0] {
        OSM_ST_LOAD = 2'h1,
        OSM_ST_RUN = 2'h2
    } osm_state_e;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] wdata;
    } osm_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } osm_rsp_s;

    typedef struct packed {
        osm_state_e state;
        logic [7:0] nv_cfg5;
        logic [7:0] vol_cfg5;
        osm_rsp_s rsp;
        logic [7:0] tbl_data;
        logic tbl_valid;
        logic octal_en;
    } osm_state_s;

endpackage

// >>> rtl/osm_select_map.sv
// eight-lane select registers reached by addressed register commands,
// plus the parameter table bytes that describe them
// assumes the serial front end has decoded command, address and data into one
// request pulse, all synchronous to i_clk
`timescale 1ns/1ps
`include "osm_params.svh"

module osm_select_map #(
    parameter logic [7:0] NV_DEFAULT = `OSM_NV_CFG5_DEFAULT
) (
    input wire logic i_clk, // 10 MHz clock
    input wire logic i_sys_rst, // synchronous reset, active high
    input wire logic i_por, // power-on, clears stored copy, active high
    input wire osm_pkg::osm_req_s i_req, // decoded register command
    input wire logic i_tbl_rd, // table byte read strobe
    input wire logic [8:0] i_tbl_addr, // table byte address
    output osm_pkg::osm_rsp_s o_rsp, // register command answer
    output logic [7:0] o_tbl_data, // table byte
    output logic o_tbl_valid, // table byte valid pulse
    output logic o_octal_en // eight-lane operation selected
);

    osm_pkg::osm_state_s cur;
    osm_pkg::osm_state_s next_cur;
    logic [7:0] tbl_byte;

    function automatic logic is_nv(input logic [23:0] a);
        is_nv = (a == `OSM_ADDR_NV_CFG5);
    endfunction

    function automatic logic is_vol(input logic [23:0] a);
        is_vol = (a == `OSM_ADDR_VOL_CFG5);
    endfunction

    osm_table u_table (
        .i_addr(i_tbl_addr),
        .o_data(tbl_byte)
    );

    always_comb begin
        next_cur = cur;
        next_cur.rsp = '0;
        next_cur.tbl_valid = 1'b0;
        case (cur.state)
            osm_pkg::OSM_ST_LOAD: begin
                // stored setting decides lane count before any command is served
                next_cur.vol_cfg5 = cur.nv_cfg5;
                next_cur.state = osm_pkg::OSM_ST_RUN;
            end
            osm_pkg::OSM_ST_RUN: begin
                if (i_req.valid) begin
                    case (i_req.cmd)
                        `OSM_CMD_WR_REG: begin
                            // the stored copy has no lock, so every write lands
                            if (is_nv(i_req.addr)) begin
                                next_cur.nv_cfg5 = i_req.wdata;
                            end else if (is_vol(i_req.addr)) begin
                                next_cur.vol_cfg5 = i_req.wdata;
                            end else begin
                                next_cur.rsp.err = 1'b1;
                            end
                            next_cur.rsp.valid = 1'b1;
                        end
                        `OSM_CMD_RD_REG: begin
                            if (is_nv(i_req.addr)) begin
                                next_cur.rsp.data = cur.nv_cfg5;
                            end else if (is_vol(i_req.addr)) begin
                                next_cur.rsp.data = cur.vol_cfg5;
                            end else begin
                                next_cur.rsp.err = 1'b1;
                            end
                            next_cur.rsp.valid = 1'b1;
                        end
                        default: begin
                            // no bit-set commands exist; anything else is refused
                            next_cur.rsp.valid = 1'b1;
                            next_cur.rsp.err = 1'b1;
                        end
                    endcase
                end
            end
            default: next_cur.state = osm_pkg::OSM_ST_LOAD;
        endcase
        if (i_tbl_rd) begin
            next_cur.tbl_data = tbl_byte;
            next_cur.tbl_valid = 1'b1;
        end
        // positive polarity: a one in bit zero means eight lanes
        next_cur.octal_en = next_cur.vol_cfg5[`OSM_SEL_BIT];
        if (i_sys_rst) begin
            next_cur.state = osm_pkg::OSM_ST_LOAD;
            next_cur.vol_cfg5 = `OSM_VOL_CFG5_RESET;
            next_cur.rsp = '0;
            next_cur.tbl_data = `OSM_TBL_FILL;
            next_cur.tbl_valid = 1'b0;
            next_cur.octal_en = 1'b0;
        end
        // the stored copy survives a plain reset; only power-on clears it
        if (i_por) begin
            next_cur.nv_cfg5 = NV_DEFAULT;
        end
    end

    always_ff @(posedge i_clk) begin
        cur <= next_cur;
    end

    assign o_rsp = cur.rsp;
    assign o_tbl_data = cur.tbl_data;
    assign o_tbl_valid = cur.tbl_valid;
    assign o_octal_en = cur.octal_en;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    vol_write_lands_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_WR_REG
        && i_req.addr == `OSM_ADDR_VOL_CFG5 |=> cur.vol_cfg5 == $past(i_req.wdata)
        && o_rsp.valid && !o_rsp.err)
        else $error("volatile write not stored");

    reg_read_answer_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_RD_REG
        && i_req.addr == `OSM_ADDR_NV_CFG5 |=> o_rsp.valid && o_rsp.data == $past(cur.nv_cfg5))
        else $error("register read returned wrong data");

    vol_addr_only_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_WR_REG
        && i_req.addr != `OSM_ADDR_VOL_CFG5 |=> $stable(cur.vol_cfg5))
        else $error("volatile copy changed by other address");

    lane_select_bit_a: assert property (
        ##1 o_octal_en == cur.vol_cfg5[0])
        else $error("lane select not bit zero");

    positive_polarity_a: assert property (
        $rose(cur.vol_cfg5[0]) |-> o_octal_en)
        else $error("one in select bit did not enable lanes");

    no_bitset_cmd_a: assert property (
        i_req.valid && i_req.cmd != `OSM_CMD_WR_REG && !i_por
        |=> $stable(cur.nv_cfg5) && ($past(cur.state) != osm_pkg::OSM_ST_RUN || o_rsp.valid))
        else $error("select bit changed without addressed write");

    nv_rewrite_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_WR_REG
        && i_req.addr == `OSM_ADDR_NV_CFG5 && !i_por |=> cur.nv_cfg5 == $past(i_req.wdata))
        else $error("stored select copy refused rewrite");

    vol_desc_bytes_a: assert property (
        i_tbl_rd && i_tbl_addr == `OSM_TBL_VOL_DESC |=> o_tbl_valid && o_tbl_data == 8'h90)
        else $error("volatile descriptor byte wrong");

    nv_desc_bytes_a: assert property (
        i_tbl_rd && i_tbl_addr == `OSM_TBL_NV_ADDR ##1 i_tbl_rd && i_tbl_addr == `OSM_TBL_NV_DESC
        |=> $past(o_tbl_data) == 8'h06 && o_tbl_data == 8'h90)
        else $error("stored descriptor bytes wrong");

    load_after_reset_a: assert property (
        cur.state == osm_pkg::OSM_ST_LOAD ##1 !i_sys_rst
        |-> cur.vol_cfg5 == $past(cur.nv_cfg5) || $past(i_por))
        else $error("volatile copy not loaded from stored copy");

    rsp_needs_req_a: assert property (
        !(cur.state == osm_pkg::OSM_ST_RUN && i_req.valid) |=> !o_rsp.valid)
        else $error("answer without a taken request");

    nv_addr_only_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_WR_REG
        && i_req.addr != `OSM_ADDR_NV_CFG5 && !i_por |=> $stable(cur.nv_cfg5))
        else $error("stored copy changed by other address");

    bad_addr_refused_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid
        && (i_req.cmd == `OSM_CMD_WR_REG || i_req.cmd == `OSM_CMD_RD_REG)
        && i_req.addr != `OSM_ADDR_NV_CFG5 && i_req.addr != `OSM_ADDR_VOL_CFG5
        |=> o_rsp.valid && o_rsp.err && o_rsp.data == 8'h00)
        else $error("unmapped register address not refused");

    vol_read_answer_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_RD_REG
        && i_req.addr == `OSM_ADDR_VOL_CFG5
        |=> o_rsp.valid && !o_rsp.err && o_rsp.data == $past(cur.vol_cfg5))
        else $error("volatile read returned wrong data");

    nv_write_ack_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd == `OSM_CMD_WR_REG
        && i_req.addr == `OSM_ADDR_NV_CFG5 |=> o_rsp.valid && !o_rsp.err)
        else $error("stored copy write not acknowledged");

    stored_polarity_a: assert property (
        cur.state == osm_pkg::OSM_ST_LOAD
        |=> {7'h00, o_octal_en} == ($past(cur.nv_cfg5) & 8'h01))
        else $error("stored one did not select eight lanes");

    bad_cmd_no_change_a: assert property (
        cur.state == osm_pkg::OSM_ST_RUN && i_req.valid && i_req.cmd != `OSM_CMD_WR_REG
        && i_req.cmd != `OSM_CMD_RD_REG
        |=> o_rsp.valid && o_rsp.err && $stable(cur.vol_cfg5))
        else $error("unknown command accepted");

    tbl_valid_pulse_a: assert property (
        !i_tbl_rd |=> !o_tbl_valid)
        else $error("table byte valid without a read");

    tbl_data_holds_a: assert property (
        !i_tbl_rd |=> $stable(o_tbl_data))
        else $error("table byte changed without a read");

    vol_cmd_bytes_a: assert property (
        i_tbl_rd && i_tbl_addr == `OSM_TBL_VOL_WR
        ##1 i_tbl_rd && i_tbl_addr == `OSM_TBL_VOL_RD
        |=> $past(o_tbl_data) == 8'h71 && o_tbl_data == 8'h65)
        else $error("volatile descriptor command bytes wrong");

endmodule // osm_select_map

// >>> rtl/osm_table.sv
// parameter table bytes that describe how the eight-lane mode is switched
// assumes a registered consumer; lookup is purely combinational
`timescale 1ns/1ps
`include "osm_params.svh"

module osm_table (
    input wire logic [8:0] i_addr, // table byte address
    output logic [7:0] o_data // byte at that address
);

    function automatic logic [7:0] desc_top(input logic nv);
        // supported, positive polarity, written by addressed command, location 000b
        desc_top = {`OSM_DESC_SUPPORTED, `OSM_DESC_POL_POSITIVE,
                    (nv ? `OSM_DESC_NO_OTP : `OSM_DESC_RSVD), `OSM_DESC_BY_ADDR_CMD,
                    `OSM_DESC_RSVD, `OSM_DESC_BITLOC};
    endfunction

    always_comb begin
        case (i_addr)
            `OSM_TBL_UNSUPP_A: o_data = `OSM_TBL_NOT_SUPP;
            `OSM_TBL_UNSUPP_B: o_data = `OSM_TBL_NOT_SUPP;
            `OSM_TBL_VOL_WR: o_data = `OSM_CMD_WR_REG;
            `OSM_TBL_VOL_RD: o_data = `OSM_CMD_RD_REG;
            // only the low address byte fits the descriptor field
            `OSM_TBL_VOL_ADDR: o_data = 8'(`OSM_ADDR_VOL_CFG5 & 24'h0000FF);
            `OSM_TBL_VOL_DESC: o_data = desc_top(1'b0);
            `OSM_TBL_NV_WR: o_data = `OSM_CMD_WR_REG;
            `OSM_TBL_NV_RD: o_data = `OSM_CMD_RD_REG;
            `OSM_TBL_NV_ADDR: o_data = 8'(`OSM_ADDR_NV_CFG5 & 24'h0000FF);
            `OSM_TBL_NV_DESC: o_data = desc_top(1'b1);
            default: o_data = `OSM_TBL_FILL;
        endcase
    end

endmodule // osm_table

// >>> test/osm_host_model.sv
// host flash controller model: issues decoded register commands and table reads
// assumes callers enter each task 10 ns after a rising edge of i_clk
`timescale 1ns/1ps

module osm_host_model (
    input wire logic i_clk, // device clock
    input wire osm_pkg::osm_rsp_s i_rsp, // register command answer
    input wire logic [7:0] i_tbl_data, // table byte
    input wire logic i_tbl_valid, // table byte valid
    output osm_pkg::osm_req_s o_req, // register command
    output logic o_tbl_rd, // table read strobe
    output logic [8:0] o_tbl_addr // table byte address
);
    osm_pkg::osm_rsp_s rsp_seen;
    logic [7:0] tbl_seen;
    logic tv_seen;

    initial begin
        o_req = '0;
        o_tbl_rd = 1'b0;
        o_tbl_addr = 9'h000;
    end

    // every command code, register or not, is issued with an address and a data byte
    task automatic reg_cmd(input logic [7:0] cmd, input logic [23:0] addr,
                           input logic [7:0] wdata);
        o_req <= {1'b1, cmd, addr, wdata};
        @(posedge i_clk);
        #10;
        rsp_seen = i_rsp;
    endtask

    // released fields flip so a stale value never looks meaningful
    task automatic idle();
        o_req <= {1'b0, ~o_req.cmd, ~o_req.addr, ~o_req.wdata};
        o_tbl_rd <= 1'b0;
        o_tbl_addr <= ~o_tbl_addr;
        @(posedge i_clk);
        #10;
    endtask

    task automatic tbl_read(input logic [8:0] a);
        o_tbl_rd <= 1'b1;
        o_tbl_addr <= a;
        @(posedge i_clk);
        #10;
        tbl_seen = i_tbl_data;
        tv_seen = i_tbl_valid;
    endtask
endmodule // osm_host_model

// >>> test/sfdp_octal_select_map_test.sv
// self-checking bench of the eight-lane select map
// assumes osm_pkg and the design files are compiled first
`timescale 1ns/1ps

module sfdp_octal_select_map_test;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_por = 1'b1;
    osm_pkg::osm_req_s req;
    osm_pkg::osm_rsp_s rsp;
    logic tbl_rd, tbl_valid, octal_en;
    logic [8:0] tbl_addr;
    logic [7:0] tbl_data, w, nv, c;
    int mismatches = 0;
    int checks = 0;

    always #50 i_clk = ~i_clk;

    osm_select_map dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por(i_por), .i_req(req),
        .i_tbl_rd(tbl_rd), .i_tbl_addr(tbl_addr), .o_rsp(rsp), .o_tbl_data(tbl_data),
        .o_tbl_valid(tbl_valid), .o_octal_en(octal_en));
    osm_host_model host (.i_clk(i_clk), .i_rsp(rsp), .i_tbl_data(tbl_data),
        .i_tbl_valid(tbl_valid), .o_req(req), .o_tbl_rd(tbl_rd), .o_tbl_addr(tbl_addr));

    // descriptor top byte: supported, positive, no lock, by address, bit 0
    function automatic logic [7:0] tbl_exp(input logic [8:0] a);
        case (a)
            9'h1A2, 9'h1A6: return 8'hFF;
            9'h1A8, 9'h1AC: return 8'h71;
            9'h1A9, 9'h1AD: return 8'h65;
            9'h1AA, 9'h1AE: return 8'h06;
            9'h1AB, 9'h1AF: return {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0};
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic status(input logic [7:0] exp);
        check({host.rsp_seen.valid, host.rsp_seen.err, 6'h00}, exp);
    endtask

    task automatic rd(input logic [23:0] a, input logic [7:0] exp);
        host.reg_cmd(8'h65, a, 8'h00);
        status(8'h80);
        check(host.rsp_seen.data, exp);
    endtask

    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        host.reg_cmd(8'h71, a, d);
        status(8'h80);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #1000000;
        mismatches++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hA2FAA0AE));
        repeat (20) @(posedge i_clk);
        #10;
        i_sys_rst = 1'b0;
        i_por = 1'b0;
        repeat (3) host.idle();
        check({7'h00, octal_en}, 8'h00);
        rd(24'h000006, 8'h00);
        rd(24'h800006, 8'h00);
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 8'h01 : (i == 1) ? 8'hFE : 8'($urandom);
            wr(24'h800006, w);
            rd(24'h800006, w);
            check({7'h00, octal_en}, {7'h00, w[0]});
            repeat ($urandom_range(0, 2)) host.idle();
        end
        // repeated rewrites of the stored copy must all stick
        for (int i = 0; i < 4; i++) begin
            nv = 8'($urandom);
            nv[0] = i[0];
            wr(24'h000006, nv);
            rd(24'h000006, nv);
        end
        i_sys_rst = 1'b1;
        host.idle();
        i_sys_rst = 1'b0;
        repeat (3) host.idle();
        check({7'h00, octal_en}, {7'h00, nv[0]});
        rd(24'h800006, nv);
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 8'h01 : (i == 1) ? 8'h05 : (i == 2) ? 8'h35 : 8'($urandom);
            if (c != 8'h71 && c != 8'h65) begin
                host.reg_cmd(c, 24'h800006, ~nv);
                status(8'hC0);
                rd(24'h800006, nv);
            end
        end
        // a write to a neighbouring address must be refused and change nothing
        host.reg_cmd(8'h71, 24'h800007, ~nv);
        status(8'hC0);
        rd(24'h800006, nv);
        host.reg_cmd(8'h65, 24'h000007, 8'h00);
        status(8'hC0);
        check(host.rsp_seen.data, 8'h00);
        host.idle();
        for (int a = 9'h1A0; a <= 9'h1B0; a++) begin
            host.tbl_read(9'(a));
            check({7'h00, host.tv_seen}, 8'h01);
            check(host.tbl_seen, tbl_exp(9'(a)));
        end
        host.idle();
        // power-on clears the stored copy, so the lane count falls back to one
        i_sys_rst = 1'b1;
        i_por = 1'b1;
        host.idle();
        i_sys_rst = 1'b0;
        i_por = 1'b0;
        repeat (3) host.idle();
        check({7'h00, octal_en}, 8'h00);
        rd(24'h000006, 8'h00);
        rd(24'h800006, 8'h00);
        host.idle();
        give_verdict();
    end
endmodule // sfdp_octal_select_map_test
